// ---- src/seb_pkg.sv ----
// Behaviour
// (RULE_01) Driver latch open: shared enable bus drives output driver enables directly.
// (RULE_02) Driver enable one turns its serial driver on, zero powers it down.
// (RULE_03) Driver gate falling captures the bus value and holds it.
// (RULE_04) Device reset clears the driver latch, disabling every serial driver.
// (RULE_05) Self-test latch open: shared bus drives transmit and receive self-test enables.
// (RULE_06) Self-test bit zero runs test generate or compare; one means normal operation.
// (RULE_07) Self-test gate falling captures the bus value and holds it.
// (RULE_08) Reset while self-test latch closed clears it, disabling self-test everywhere.
// (RULE_09) Receive-power latch open: shared bus drives receive PLL and analog power enables.
// (RULE_10) Receive-power bit one keeps channel active, zero powers it down.
// (RULE_11) Receive-power gate falling captures the bus value and holds it.
// (RULE_12) Device reset clears the receive-power latch, disabling all receive channels.
// (RULE_13) Input select high routes the channel's serial input to its recovery circuit.
// (RULE_14) Host keeps bus stable from raising a gate until it falls again.
// (RULE_15) Device reset is active low, clocked; outputs settle within 16 cycles.
// (RULE_16) Bus bits map two per channel, transmit and receive, via a changeable table.
// (RULE_17) Gates are synchronised; capture on detected fall; latches update independently.
package seb_pkg;

  localparam int CHANNELS = 4;
  localparam int BUS_W    = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;

  // Bus bit index per channel, editable if the board uses another order
  localparam logic [CHANNELS-1:0][2:0] TX_BIT_MAP = {3'h6, 3'h4, 3'h2, 3'h0}; // RULE_16
  localparam logic [CHANNELS-1:0][2:0] RX_BIT_MAP = {3'h7, 3'h5, 3'h3, 3'h1}; // RULE_16

  // Reset values of the three latches
  localparam logic [BUS_W-1:0] DRV_RESET   = 8'h00;
  localparam logic [BUS_W-1:0] BIST_RESET  = 8'hFF;
  localparam logic [BUS_W-1:0] RXPWR_RESET = 8'h00;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_INSEL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DRV    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_BIST   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RXPWR  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

  // Status field positions
  localparam int ST_DRV_CAP   = 0;
  localparam int ST_BIST_CAP  = 1;
  localparam int ST_RXPWR_CAP = 2;
  localparam int ST_READY     = 3;

  localparam logic [CHANNELS-1:0] INSEL_RESET = 4'h0;
  localparam logic [DATA_W-1:0]   READ_ZERO   = 8'h00;

  // Settle window after device reset release
  localparam int          READY_CYCLES = 16;
  localparam logic [4:0]  READY_LAST   = 5'(READY_CYCLES - 2);
  localparam logic [4:0]  CNT_ZERO     = 5'h00;
  localparam logic [4:0]  CNT_ONE      = 5'h01;

endpackage : seb_pkg

// ---- src/seb_gate_sync.sv ----
module seb_gate_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Gate
  input  wire logic gateIn,
  output logic      gateOpen,
  output logic      gateFell
);
  import seb_pkg::*;

  logic meta_q;
  logic level_q;
  logic prev_q;

  // Gate pin is asynchronous at the device edge
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_17
    if (!rst_b) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= gateIn;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  assign gateOpen = level_q;
  assign gateFell = prev_q & ~level_q; // RULE_17

endmodule : seb_gate_sync

// ---- src/seb_enable_latch.sv ----
module seb_enable_latch #(
  parameter logic [seb_pkg::BUS_W-1:0] RESET_VAL       = 8'h00,
  parameter bit                        CLEAR_WHEN_OPEN = 1'b1
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Control
  input  wire logic                      gateOpen,
  input  wire logic                      clearReq,
  input  wire logic [seb_pkg::BUS_W-1:0] busIn,
  // State
  output logic      [seb_pkg::BUS_W-1:0] state
);
  import seb_pkg::*;

  logic [BUS_W-1:0] state_q;

  // Transparent while open, holds last open value once closed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RESET_VAL;
    end else if (clearReq && (CLEAR_WHEN_OPEN || !gateOpen)) begin
      state_q <= RESET_VAL; // RULE_04 RULE_08 RULE_12
    end else if (gateOpen) begin
      state_q <= busIn; // RULE_01 RULE_05 RULE_09
    end
  end

  assign state = state_q; // RULE_03 RULE_07 RULE_11

endmodule : seb_enable_latch

// ---- src/seb_enable_latch_bank.sv ----
module seb_enable_latch_bank (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  // Host control pins
  input  wire logic                         device_reset_n,
  input  wire logic [seb_pkg::BUS_W-1:0]    sharedEnableBus,
  input  wire logic                         driverLatchGate,
  input  wire logic                         selftestLatchGate,
  input  wire logic                         rxPowerLatchGate,
  // Serial data
  input  wire logic [seb_pkg::CHANNELS-1:0] txSerial,
  input  wire logic [seb_pkg::CHANNELS-1:0] serialInPair,
  output logic      [seb_pkg::CHANNELS-1:0] serialOutPair,
  output logic      [seb_pkg::CHANNELS-1:0] cdrData,
  // Channel enables and settle flag
  output logic      [seb_pkg::CHANNELS-1:0] driverEnable,
  output logic      [seb_pkg::CHANNELS-1:0] txSelfTestOn,
  output logic      [seb_pkg::CHANNELS-1:0] rxSelfTestOn,
  output logic      [seb_pkg::CHANNELS-1:0] rxPowerOn,
  output logic                              resetDone,
  // Register port
  input  wire logic [seb_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [seb_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                         regWrStb,
  input  wire logic                         regRdStb,
  output logic      [seb_pkg::DATA_W-1:0]   regRdData
);
  import seb_pkg::*;

  logic                devRstHeld_q;
  logic [BUS_W-1:0]    busMeta_q;
  logic [BUS_W-1:0]    busAlign_q;
  logic                drvOpen;
  logic                drvFell;
  logic                bistOpen;
  logic                bistFell;
  logic                rxOpen;
  logic                rxFell;
  logic [BUS_W-1:0]    drvState;
  logic [BUS_W-1:0]    bistState;
  logic [BUS_W-1:0]    rxState;
  logic [CHANNELS-1:0] drvMapped;
  logic [CHANNELS-1:0] bistTxMapped;
  logic [CHANNELS-1:0] bistRxMapped;
  logic [CHANNELS-1:0] rxMapped;
  logic [CHANNELS-1:0] inputSel_q;
  logic [2:0]          captured_q;
  logic [4:0]          readyCnt_q;
  logic                resetDone_q;
  logic [CHANNELS-1:0] serialOut_q;
  logic [CHANNELS-1:0] cdrData_q;
  logic [CHANNELS-1:0] driverEnable_q;
  logic [CHANNELS-1:0] txSelfTestOn_q;
  logic [CHANNELS-1:0] rxSelfTestOn_q;
  logic [CHANNELS-1:0] rxPowerOn_q;
  logic [DATA_W-1:0]   regRdData_q;
  logic                statusWr;

  // Reset pin sampled on the clock, not used as an async reset
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_15
    if (!rst_b) begin
      devRstHeld_q <= 1'b1;
    end else begin
      devRstHeld_q <= !device_reset_n;
    end
  end

  // Bus delayed to line up with the synchronised gates
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_14
    if (!rst_b) begin
      busMeta_q  <= DRV_RESET;
      busAlign_q <= DRV_RESET;
    end else begin
      busMeta_q  <= sharedEnableBus;
      busAlign_q <= busMeta_q;
    end
  end

  seb_gate_sync u_drv_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateIn   (driverLatchGate),
    .gateOpen (drvOpen),
    .gateFell (drvFell)
  );

  seb_gate_sync u_bist_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateIn   (selftestLatchGate),
    .gateOpen (bistOpen),
    .gateFell (bistFell)
  );

  seb_gate_sync u_rx_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateIn   (rxPowerLatchGate),
    .gateOpen (rxOpen),
    .gateFell (rxFell)
  );

  seb_enable_latch #(
    .RESET_VAL       (DRV_RESET),
    .CLEAR_WHEN_OPEN (1'b1)
  ) u_drv_latch (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateOpen (drvOpen),
    .clearReq (devRstHeld_q),
    .busIn    (busAlign_q),
    .state    (drvState)
  );

  // Self-test latch only clears while closed
  seb_enable_latch #(
    .RESET_VAL       (BIST_RESET),
    .CLEAR_WHEN_OPEN (1'b0)
  ) u_bist_latch (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateOpen (bistOpen),
    .clearReq (devRstHeld_q),
    .busIn    (busAlign_q),
    .state    (bistState)
  );

  seb_enable_latch #(
    .RESET_VAL       (RXPWR_RESET),
    .CLEAR_WHEN_OPEN (1'b1)
  ) u_rx_latch (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .gateOpen (rxOpen),
    .clearReq (devRstHeld_q),
    .busIn    (busAlign_q),
    .state    (rxState)
  );

  for (genvar c = 0; c < CHANNELS; c++) begin : g_map
    assign drvMapped[c]    = drvState[TX_BIT_MAP[c]]; // RULE_16
    assign bistTxMapped[c] = bistState[TX_BIT_MAP[c]]; // RULE_16
    assign bistRxMapped[c] = bistState[RX_BIT_MAP[c]]; // RULE_16
    assign rxMapped[c]     = rxState[RX_BIT_MAP[c]]; // RULE_16
  end

  // Channel controls
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      driverEnable_q <= INSEL_RESET;
      txSelfTestOn_q <= INSEL_RESET;
      rxSelfTestOn_q <= INSEL_RESET;
      rxPowerOn_q    <= INSEL_RESET;
    end else begin
      driverEnable_q <= drvMapped; // RULE_02
      txSelfTestOn_q <= ~bistTxMapped; // RULE_06
      rxSelfTestOn_q <= ~bistRxMapped; // RULE_06
      rxPowerOn_q    <= rxMapped; // RULE_10
    end
  end

  // Disabled drivers sit at zero instead of toggling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serialOut_q <= INSEL_RESET;
      cdrData_q   <= INSEL_RESET;
    end else begin
      serialOut_q <= txSerial & drvMapped; // RULE_02
      cdrData_q   <= serialInPair & inputSel_q; // RULE_13
    end
  end

  // Settle counter after device reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_15
    if (!rst_b) begin
      readyCnt_q  <= CNT_ZERO;
      resetDone_q <= 1'b0;
    end else if (devRstHeld_q) begin
      readyCnt_q  <= CNT_ZERO;
      resetDone_q <= 1'b0;
    end else if (readyCnt_q != READY_LAST) begin
      readyCnt_q  <= readyCnt_q + CNT_ONE;
    end else begin
      resetDone_q <= 1'b1;
    end
  end

  assign statusWr = regWrStb && (regAddr == REG_STATUS);

  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_13
    if (!rst_b) begin
      inputSel_q <= INSEL_RESET;
    end else if (regWrStb && (regAddr == REG_INSEL)) begin
      inputSel_q <= regWrData[CHANNELS-1:0];
    end
  end

  // Capture flags: a new fall beats a write-one clear
  always_ff @(posedge sys_clk or negedge rst_b) begin // RULE_17
    if (!rst_b) begin
      captured_q <= 3'h0;
    end else begin
      captured_q[ST_DRV_CAP] <= drvFell ||
        (captured_q[ST_DRV_CAP] && !(statusWr && regWrData[ST_DRV_CAP]));
      captured_q[ST_BIST_CAP] <= bistFell ||
        (captured_q[ST_BIST_CAP] && !(statusWr && regWrData[ST_BIST_CAP]));
      captured_q[ST_RXPWR_CAP] <= rxFell ||
        (captured_q[ST_RXPWR_CAP] && !(statusWr && regWrData[ST_RXPWR_CAP]));
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_q <= READ_ZERO;
    end else if (!regRdStb) begin
      regRdData_q <= READ_ZERO;
    end else if (regAddr == REG_INSEL) begin
      regRdData_q <= {4'h0, inputSel_q};
    end else if (regAddr == REG_DRV) begin
      regRdData_q <= drvState;
    end else if (regAddr == REG_BIST) begin
      regRdData_q <= bistState;
    end else if (regAddr == REG_RXPWR) begin
      regRdData_q <= rxState;
    end else if (regAddr == REG_STATUS) begin
      regRdData_q <= {4'h0, resetDone_q, captured_q};
    end else begin
      regRdData_q <= READ_ZERO;
    end
  end

  assign serialOutPair = serialOut_q;
  assign cdrData       = cdrData_q;
  assign driverEnable  = driverEnable_q;
  assign txSelfTestOn  = txSelfTestOn_q;
  assign rxSelfTestOn  = rxSelfTestOn_q;
  assign rxPowerOn     = rxPowerOn_q;
  assign resetDone     = resetDone_q;
  assign regRdData     = regRdData_q;

  sequence s_fall_clean(logic fell);
    fell && !devRstHeld_q && !$past(devRstHeld_q);
  endsequence

  sequence s_open_run(logic open);
    open && !devRstHeld_q;
  endsequence

  a_drv_follow_bus: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (!rst_b)
    s_open_run(drvOpen) |=> drvState == $past(busAlign_q))
    else $error("driver latch did not follow bus while open");

  a_drv_out_gate: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 (driverEnable_q == $past(drvMapped)) && ((serialOut_q & ~driverEnable_q) == 4'h0))
    else $error("serial driver enable or power-down wrong");

  a_drv_fall_hold: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (!rst_b)
    s_fall_clean(drvFell) |-> drvState == $past(busAlign_q))
    else $error("driver latch lost last open value");

  a_drv_reset_clear: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (!rst_b)
    devRstHeld_q |=> drvState == DRV_RESET ##1 driverEnable_q == 4'h0)
    else $error("driver latch not cleared by device reset");

  a_bist_follow_bus: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (!rst_b)
    bistOpen |=> bistState == $past(busAlign_q))
    else $error("self-test latch did not follow bus while open");

  a_bist_polarity: assert property ( // RULE_06
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 (txSelfTestOn_q == ~$past(bistTxMapped)) && (rxSelfTestOn_q == ~$past(bistRxMapped)))
    else $error("self-test enable polarity wrong");

  a_bist_fall_hold: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (!rst_b)
    bistFell |-> bistState == $past(busAlign_q))
    else $error("self-test latch lost last open value");

  a_bist_reset_closed: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!rst_b)
    devRstHeld_q && !bistOpen |=> bistState == BIST_RESET ##1 txSelfTestOn_q == 4'h0)
    else $error("self-test latch not cleared by reset while closed");

  a_rx_follow_bus: assert property ( // RULE_09
    @(posedge sys_clk) disable iff (!rst_b)
    s_open_run(rxOpen) |=> rxState == $past(busAlign_q))
    else $error("receive power latch did not follow bus while open");

  a_rx_power_map: assert property ( // RULE_10
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 rxPowerOn_q == $past(rxMapped))
    else $error("receive power enable wrong");

  a_rx_fall_hold: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (!rst_b)
    s_fall_clean(rxFell) |-> rxState == $past(busAlign_q))
    else $error("receive power latch lost last open value");

  a_rx_reset_clear: assert property ( // RULE_12
    @(posedge sys_clk) disable iff (!rst_b)
    devRstHeld_q |=> rxState == RXPWR_RESET ##1 rxPowerOn_q == 4'h0)
    else $error("receive power latch not cleared by device reset");

  a_insel_route: assert property ( // RULE_13
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 cdrData_q == ($past(serialInPair) & $past(inputSel_q)))
    else $error("serial input routing wrong");

  a_ready_window: assert property ( // RULE_15
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(devRstHeld_q) |-> !resetDone_q ##[1:16] resetDone_q)
    else $error("outputs not settled within window after reset");

  a_latch_indep: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (!rst_b)
    !bistOpen && !devRstHeld_q && (drvOpen || rxOpen) |=> $stable(bistState))
    else $error("closed self-test latch changed with another gate");

  a_rx_closed_hold: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (!rst_b)
    !rxOpen && !devRstHeld_q |=> $stable(rxState))
    else $error("closed receive power latch changed");

  a_bist_open_keep: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!rst_b)
    devRstHeld_q && bistOpen |=> bistState == $past(busAlign_q))
    else $error("open self-test latch cleared by device reset");

  a_drv_cap_flag: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (!rst_b)
    drvFell |=> captured_q[ST_DRV_CAP])
    else $error("driver capture flag not set on gate fall");

  a_insel_write: assert property ( // RULE_13
    @(posedge sys_clk) disable iff (!rst_b)
    regWrStb && (regAddr == REG_INSEL) |=> inputSel_q == $past(regWrData[CHANNELS-1:0]))
    else $error("input select write not taken");

  a_ready_held_low: assert property ( // RULE_15
    @(posedge sys_clk) disable iff (!rst_b)
    devRstHeld_q |=> !resetDone_q)
    else $error("settle flag set while device reset held");

endmodule : seb_enable_latch_bank

// ---- test/seb_host_model.sv ----
module seb_host_model (
  // Clock
  input  wire logic                      sys_clk,
  // Bus and gates toward the device
  output logic      [seb_pkg::BUS_W-1:0] sharedEnableBus,
  output logic                           driverLatchGate,
  output logic                           selftestLatchGate,
  output logic                           rxPowerLatchGate
);
  timeunit 1ns;
  timeprecision 100ps;
  import seb_pkg::*;

  logic [2:0] gates_q;

  assign driverLatchGate   = gates_q[0];
  assign selftestLatchGate = gates_q[1];
  assign rxPowerLatchGate  = gates_q[2];

  // Released bus floats to its pull-up level
  initial begin
    sharedEnableBus = 8'hFF;
    gates_q         = 3'h0;
  end

  // Value goes out together with the rising gate
  task automatic open_gate(input int g, input logic [BUS_W-1:0] v);
    @(posedge sys_clk);
    sharedEnableBus <= v;
    gates_q[g]      <= 1'b1;
  endtask : open_gate

  // Bus held past the fall, since the device sees the gate late
  task automatic close_gate(input int g);
    @(posedge sys_clk);
    gates_q[g] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sharedEnableBus <= 8'hFF;
  endtask : close_gate

endmodule : seb_host_model

// ---- test/seb_enable_latch_bank_tb.sv ----
module seb_enable_latch_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import seb_pkg::*;

  logic                sys_clk;
  logic                rst_b;
  logic                device_reset_n;
  logic [BUS_W-1:0]    sharedEnableBus;
  logic                driverLatchGate;
  logic                selftestLatchGate;
  logic                rxPowerLatchGate;
  logic [CHANNELS-1:0] txSerial;
  logic [CHANNELS-1:0] serialInPair;
  logic [CHANNELS-1:0] serialOutPair;
  logic [CHANNELS-1:0] cdrData;
  logic [CHANNELS-1:0] driverEnable;
  logic [CHANNELS-1:0] txSelfTestOn;
  logic [CHANNELS-1:0] rxSelfTestOn;
  logic [CHANNELS-1:0] rxPowerOn;
  logic                resetDone;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWrData;
  logic                regWrStb;
  logic                regRdStb;
  logic [DATA_W-1:0]   regRdData;
  logic [DATA_W-1:0]   rd;
  logic [BUS_W-1:0]    lat [3];
  logic [BUS_W-1:0]    vals [3];
  int                  n_fail;
  int                  comparisons;

  seb_host_model seb_host_model_inst (
    .sys_clk           (sys_clk),
    .sharedEnableBus   (sharedEnableBus),
    .driverLatchGate   (driverLatchGate),
    .selftestLatchGate (selftestLatchGate),
    .rxPowerLatchGate  (rxPowerLatchGate)
  );

  seb_enable_latch_bank seb_enable_latch_bank_inst (
    .sys_clk           (sys_clk),
    .rst_b             (rst_b),
    .device_reset_n    (device_reset_n),
    .sharedEnableBus   (sharedEnableBus),
    .driverLatchGate   (driverLatchGate),
    .selftestLatchGate (selftestLatchGate),
    .rxPowerLatchGate  (rxPowerLatchGate),
    .txSerial          (txSerial),
    .serialInPair      (serialInPair),
    .serialOutPair     (serialOutPair),
    .cdrData           (cdrData),
    .driverEnable      (driverEnable),
    .txSelfTestOn      (txSelfTestOn),
    .rxSelfTestOn      (rxSelfTestOn),
    .rxPowerOn         (rxPowerOn),
    .resetDone         (resetDone),
    .regAddr           (regAddr),
    .regWrData         (regWrData),
    .regWrStb          (regWrStb),
    .regRdStb          (regRdStb),
    .regRdData         (regRdData)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask : rdreg

  // Bounded wait for the settle window to end
  task automatic wait_done;
    for (int i = 0; i < 20 && resetDone !== 1'b1; i++) @(posedge sys_clk);
    #1 chk("resetDone", {7'h00, resetDone}, 8'h01);
    if (resetDone !== 1'b1) complete_run();
  endtask : wait_done

  // Every latch-driven channel output against the expected latch contents
  task automatic check_all;
    logic [CHANNELS-1:0] drv;
    logic [CHANNELS-1:0] txb;
    logic [CHANNELS-1:0] rxb;
    logic [CHANNELS-1:0] rxp;
    for (int c = 0; c < CHANNELS; c++) begin
      drv[c] = lat[0][TX_BIT_MAP[c]];
      txb[c] = ~lat[1][TX_BIT_MAP[c]];
      rxb[c] = ~lat[1][RX_BIT_MAP[c]];
      rxp[c] = lat[2][RX_BIT_MAP[c]];
    end
    #1;
    chk("driverEnable", {4'h0, driverEnable}, {4'h0, drv});
    chk("serialOutPair", {4'h0, serialOutPair}, {4'h0, drv & txSerial});
    chk("txSelfTestOn", {4'h0, txSelfTestOn}, {4'h0, txb});
    chk("rxSelfTestOn", {4'h0, rxSelfTestOn}, {4'h0, rxb});
    chk("rxPowerOn", {4'h0, rxPowerOn}, {4'h0, rxp});
  endtask : check_all

  initial begin
    rst_b          = 1'b0;
    device_reset_n = 1'b1;
    regAddr        = 8'h00;
    regWrData      = 8'h00;
    regWrStb       = 1'b0;
    regRdStb       = 1'b0;
    txSerial       = 4'h0;
    serialInPair   = 4'h0;
    n_fail         = 0;
    comparisons    = 0;
    lat            = '{DRV_RESET, BIST_RESET, RXPWR_RESET};
    vals           = '{8'h35, 8'h96, 8'hC3};
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_done();
    check_all();
    @(posedge sys_clk);
    txSerial     <= 4'hF;
    serialInPair <= 4'hF;
    // Each latch loaded in turn; the others must keep their contents
    for (int g = 0; g < 3; g++) begin
      seb_host_model_inst.open_gate(g, vals[g]);
      lat[g] = vals[g];
      repeat (5) @(posedge sys_clk);
      check_all();
      seb_host_model_inst.close_gate(g);
      repeat (6) @(posedge sys_clk);
      check_all();
      rdreg(8'(4 * g + 4), rd);
      chk("latch register", rd, lat[g]);
    end
    rdreg(REG_STATUS, rd);
    chk("status", rd, 8'h0F);
    wr(REG_STATUS, 8'h07);
    rdreg(REG_STATUS, rd);
    chk("status cleared", rd, 8'h08);
    wr(REG_DRV, 8'hAA);
    rdreg(REG_DRV, rd);
    chk("driver latch read only", rd, lat[0]);
    rdreg(8'h20, rd);
    chk("unmapped", rd, READ_ZERO);
    wr(REG_INSEL, 8'hF5);
    rdreg(REG_INSEL, rd);
    chk("input select", rd, 8'h05);
    repeat (2) @(posedge sys_clk);
    #1 chk("cdrData", {4'h0, cdrData}, 8'h05);
    // Device reset pin, sampled on the clock, clears all three latches
    @(posedge sys_clk);
    device_reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("resetDone low", {7'h00, resetDone}, 8'h00);
    @(posedge sys_clk);
    device_reset_n <= 1'b1;
    lat = '{DRV_RESET, BIST_RESET, RXPWR_RESET};
    wait_done();
    check_all();
    // Device reset with the self-test gate open leaves that latch alone
    seb_host_model_inst.open_gate(1, 8'h5A);
    lat[1] = 8'h5A;
    repeat (3) @(posedge sys_clk);
    device_reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    device_reset_n <= 1'b1;
    wait_done();
    check_all();
    rdreg(REG_BIST, rd);
    chk("self-test kept", rd, 8'h5A);
    seb_host_model_inst.close_gate(1);
    repeat (6) @(posedge sys_clk);
    check_all();
    complete_run();
  end

endmodule : seb_enable_latch_bank_tb
